// ===== hdl/ubm_top.sv
// Purpose: Endpoint buffers, iso memory, vectors and default personality.
// Assumes: Serial engine ends every accepted packet with sie_done.
// Notes: CPU and engine writes in one cycle to one byte: engine wins.
`timescale 1ns/100ps
module ubm_top
    import ubm_pkg::*;
#(
    parameter logic [15:0] VENDOR_ID  = 16'hA5A5, // Arbitrary value.
    parameter logic [15:0] PRODUCT_ID = 16'h5A5A, // Arbitrary value.
    parameter logic [15:0] DEVICE_ID  = 16'h0101  // Arbitrary value.
) (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        tok_valid,
    input  wire logic        tok_in,
    input  wire logic        tok_setup,
    input  wire logic [3:0]  tok_ep,
    output logic             ack_valid,
    output logic             ack_nak,
    output logic [6:0]       ack_len,
    input  wire logic        sie_wr,
    input  wire logic        sie_rd,
    input  wire logic [7:0]  sie_wdata,
    output logic [7:0]       sie_rdata,
    input  wire logic        sie_done,
    input  wire logic        sof,
    input  wire logic        sie_iso_wr,
    input  wire logic        sie_iso_rd,
    input  wire logic [3:0]  sie_iso_idx,
    input  wire logic [9:0]  sie_iso_ofs,
    output logic [7:0]       sie_iso_rdata,
    input  wire logic [3:0]  cpu_buf,
    input  wire logic [5:0]  cpu_addr,
    input  wire logic        cpu_wr,
    input  wire logic        cpu_rd,
    input  wire logic        cpu_auto,
    input  wire logic        cpu_ptr_load,
    input  wire logic [7:0]  cpu_wdata,
    output logic [7:0]       cpu_rdata,
    input  wire logic        cpu_hand,
    input  wire logic [6:0]  cpu_len,
    output logic [15:0]      buf_full,
    output logic [6:0]       buf_len,
    input  wire logic [2:0]  setup_addr,
    output logic [7:0]       setup_rdata,
    input  wire logic [2:0]  pair_en,
    input  wire logic        iso_cfg_wr,
    input  wire logic [3:0]  iso_cfg_idx,
    input  wire logic [5:0]  iso_cfg_units,
    output logic             iso_cfg_err,
    input  wire logic        cpu_iso_wr,
    input  wire logic        cpu_iso_rd,
    input  wire logic [3:0]  cpu_iso_idx,
    output logic [7:0]       cpu_iso_rdata,
    input  wire logic [7:1]  inak_clr,
    output logic [7:1]       inak_flags,
    output logic             irq_req,
    output logic [4:0]       irq_vec,
    input  wire logic        irq_ack,
    input  wire logic        eeprom_present,
    input  wire logic        i2c_pulled_up,
    input  wire logic [1:0]  alt_set,
    input  wire logic [3:0]  mps_ep,
    input  wire logic        mps_in,
    output logic [8:0]       mps_bytes,
    output logic             dflt_mode,
    output logic [15:0]      id_vendor,
    output logic [15:0]      id_product,
    output logic [15:0]      id_device
);
    logic [7:0]  buf_mem [MEM_WORDS];
    logic [7:0]  setup_mem [SETUP_LEN];
    logic [7:0]  iso_mem [2*ISO_HALF];
    ubm_state_t  st_reg, st_next;
    logic [15:0] full_reg, full_next;
    logic [6:0]  len_reg [NUM_BUFS];
    logic [6:0]  len_next [NUM_BUFS];
    logic [3:0]  cur_reg, cur_next;
    logic        cset_reg, cset_next;
    logic        cpair_reg, cpair_next;
    logic [6:0]  sptr_reg, sptr_next;
    logic [2:0]  pin_reg, pin_next;
    logic [2:0]  pout_reg, pout_next;
    logic        ackv_reg, ackv_next;
    logic        nak_reg, nak_next;
    logic [6:0]  alen_reg, alen_next;
    logic [7:1]  inak_reg, inak_next;
    logic [5:0]  aptr_reg, aptr_next;
    logic [5:0]  isz_reg [NUM_ISO];
    logic [5:0]  isz_next [NUM_ISO];
    logic [9:0]  iptr_reg [NUM_ISO];
    logic [9:0]  iptr_next [NUM_ISO];
    logic        half_reg, half_next;
    logic        ierr_reg, ierr_next;
    logic        dflt_reg;
    logic [8:0]  mps_reg;
    logic [NUM_VEC-1:0] ev;
    logic [1:0]  pidx;
    logic        pair_hit, pp_sel, busy;
    logic [3:0]  tok_buf;
    logic [5:0]  cpu_eff;
    logic [9:0]  ibase [NUM_ISO];
    logic [10:0] new_total;
    logic        cpu_iso_ok;

    // Ping-pong: a paired even endpoint alternates between itself and odd.
    always_comb begin
        pidx     = 2'(tok_ep[2:1] - 2'h1);
        pair_hit = !tok_ep[3] && tok_ep[2:1] != 2'h0 && pair_en[pidx];
        pp_sel   = tok_in ? pin_reg[pidx] : pout_reg[pidx];
        tok_buf  = {tok_ep[2:1], pair_hit ? pp_sel : tok_ep[0],
                    tok_in};
        busy     = tok_in ? !full_reg[tok_buf] : full_reg[tok_buf];
        // The odd partner is hidden while paired and answers NAK.
        if (pair_hit && tok_ep[0]) begin
            busy = 1'b1;
        end
        // Zero-sized endpoints of the built-in personality are closed.
        if (dflt_reg && ubm_dflt_mps(tok_ep, tok_in, alt_set) == MPS_0) begin
            busy = 1'b1;
        end
    end

    always_comb begin
        st_next   = st_reg;
        full_next = full_reg;
        len_next  = len_reg;
        cur_next  = cur_reg;
        cset_next = cset_reg;
        cpair_next = cpair_reg;
        sptr_next = sptr_reg;
        pin_next  = pin_reg;
        pout_next = pout_reg;
        ackv_next = 1'b0;
        nak_next  = nak_reg;
        alen_next = alen_reg;
        inak_next = inak_reg;
        ev        = '0;
        if (cpu_hand) begin
            full_next[cpu_buf] = cpu_buf[0];
            len_next[cpu_buf]  = cpu_len;
        end
        case (st_reg)
            UBM_IDLE: begin
                if (tok_valid && !tok_ep[3]) begin
                    ackv_next = 1'b1;
                    sptr_next = '0;
                    cur_next  = tok_buf;
                    cset_next = tok_setup;
                    cpair_next = pair_hit && !tok_ep[0];
                    alen_next = len_reg[tok_buf];
                    nak_next  = busy && !tok_setup;
                    if (tok_setup || !busy) begin
                        st_next = UBM_XFER;
                    end else if (tok_in && tok_ep[2:0] != 3'h0) begin
                        inak_next[tok_ep[2:0]] = 1'b1;
                        ev[VEC_INAK] = 1'b1;
                    end
                end
            end
            UBM_XFER: begin
                if (sie_wr || sie_rd) begin
                    sptr_next = 7'(sptr_reg + 7'h01);
                end
                if (sie_done) begin
                    st_next = UBM_IDLE;
                    if (cset_reg) begin
                        ev[VEC_SETUP] = 1'b1;
                    end else begin
                        full_next[cur_reg] = !cur_reg[0];
                        ev[cur_reg] = 1'b1;
                        if (!cur_reg[0]) begin
                            len_next[cur_reg] = 7'(sptr_next);
                        end
                        if (cpair_reg && cur_reg[0]) begin
                            pin_next[2'(cur_reg[3:2] - 2'h1)] =
                                !pin_reg[2'(cur_reg[3:2] - 2'h1)];
                        end else if (cpair_reg) begin
                            pout_next[2'(cur_reg[3:2] - 2'h1)] =
                                !pout_reg[2'(cur_reg[3:2] - 2'h1)];
                        end
                    end
                end
            end
            default: st_next = UBM_IDLE;
        endcase
        inak_next = (inak_next & ~inak_clr) | (inak_next & ~inak_reg);
        ev[VEC_ISO] = sof;
    end

    // Auto pointer turns a bulk buffer into a byte stream for the CPU.
    always_comb begin
        cpu_eff   = cpu_auto ? aptr_reg : cpu_addr;
        aptr_next = aptr_reg;
        if (cpu_ptr_load) begin
            aptr_next = cpu_addr;
        end else if (cpu_auto && (cpu_wr || cpu_rd)) begin
            aptr_next = 6'(aptr_reg + 6'h01);
        end
    end

    // Iso regions are packed in index order; a write that would overflow
    // the shared half is refused whole, so a size never half-applies.
    always_comb begin
        logic [9:0] acc;
        acc = '0;
        for (int i = 0; i < NUM_ISO; i++) begin
            ibase[i] = acc;
            acc = 10'(acc + 10'(isz_reg[i]));
        end
        new_total = 11'(acc) - 11'(isz_reg[iso_cfg_idx]) + 11'(iso_cfg_units);
        isz_next  = isz_reg;
        ierr_next = ierr_reg;
        if (iso_cfg_wr) begin
            ierr_next = new_total > 11'(ISO_UNITS);
            if (new_total <= 11'(ISO_UNITS)) begin
                isz_next[iso_cfg_idx] = iso_cfg_units;
            end
        end
        half_next = sof ? !half_reg : half_reg;
        iptr_next = iptr_reg;
        cpu_iso_ok = iptr_reg[cpu_iso_idx] <
                     {isz_reg[cpu_iso_idx], 4'h0};
        if (sof) begin
            for (int i = 0; i < NUM_ISO; i++) begin
                iptr_next[i] = '0;
            end
        end else if ((cpu_iso_wr || cpu_iso_rd) && cpu_iso_ok) begin
            iptr_next[cpu_iso_idx] =
                10'(iptr_reg[cpu_iso_idx] + 10'h001);
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg    <= UBM_IDLE;
            full_reg  <= '0;
            cur_reg   <= '0;
            cset_reg  <= 1'b0;
            cpair_reg <= 1'b0;
            sptr_reg  <= '0;
            pin_reg   <= '0;
            pout_reg  <= '0;
            ackv_reg  <= 1'b0;
            nak_reg   <= 1'b0;
            alen_reg  <= '0;
            inak_reg  <= '0;
            aptr_reg  <= '0;
            half_reg  <= 1'b0;
            ierr_reg  <= 1'b0;
            for (int i = 0; i < NUM_ISO; i++) begin
                len_reg[i]  <= '0;
                isz_reg[i]  <= '0;
                iptr_reg[i] <= '0;
            end
        end else begin
            st_reg    <= st_next;
            full_reg  <= full_next;
            len_reg   <= len_next;
            cur_reg   <= cur_next;
            cset_reg  <= cset_next;
            cpair_reg <= cpair_next;
            sptr_reg  <= sptr_next;
            pin_reg   <= pin_next;
            pout_reg  <= pout_next;
            ackv_reg  <= ackv_next;
            nak_reg   <= nak_next;
            alen_reg  <= alen_next;
            inak_reg  <= inak_next;
            aptr_reg  <= aptr_next;
            half_reg  <= half_next;
            ierr_reg  <= ierr_next;
            isz_reg   <= isz_next;
            iptr_reg  <= iptr_next;
        end
    end

    // Built-in packet sizes apply only with pull-ups and no EEPROM; the ID outputs always apply.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dflt_reg <= 1'b0;
            mps_reg  <= '0;
        end else begin
            dflt_reg <= i2c_pulled_up && !eeprom_present;
            mps_reg  <= dflt_reg ? ubm_dflt_mps(mps_ep, mps_in, alt_set)
                                 : MPS_0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (cpu_wr) begin
            buf_mem[{cpu_buf, cpu_eff}] <= cpu_wdata;
        end
        if (st_reg == UBM_XFER && sie_wr && cset_reg) begin
            setup_mem[sptr_reg[2:0]] <= sie_wdata;
        end else if (st_reg == UBM_XFER && sie_wr) begin
            buf_mem[{cur_reg, sptr_reg[5:0]}] <= sie_wdata;
        end
        cpu_rdata   <= buf_mem[{cpu_buf, cpu_eff}];
        sie_rdata   <= buf_mem[{cur_reg, sptr_reg[5:0]}];
        setup_rdata <= setup_mem[setup_addr];
        if (cpu_iso_wr && cpu_iso_ok) begin
            iso_mem[{!half_reg, 10'(ibase[cpu_iso_idx] * 10'd16)
                     + iptr_reg[cpu_iso_idx]}] <= cpu_wdata;
        end
        if (sie_iso_wr) begin
            iso_mem[{half_reg, 10'(ibase[sie_iso_idx] * 10'd16)
                     + sie_iso_ofs}] <= sie_wdata;
        end
        cpu_iso_rdata <= iso_mem[{!half_reg, 10'(ibase[cpu_iso_idx] * 10'd16)
                                  + iptr_reg[cpu_iso_idx]}];
        sie_iso_rdata <= iso_mem[{half_reg, 10'(ibase[sie_iso_idx] * 10'd16)
                                  + sie_iso_ofs}];
    end

    ubm_irq_vec #(
        .N (NUM_VEC),
        .W (5)
    ) u_vec (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .ev_set   (ev),
        .ev_ack   (irq_ack),
        .irq_req  (irq_req),
        .irq_vec  (irq_vec)
    );

    assign ack_valid  = ackv_reg;
    assign ack_nak    = nak_reg;
    assign ack_len    = alen_reg;
    assign buf_full   = full_reg;
    assign buf_len    = len_reg[cpu_buf];
    assign iso_cfg_err = ierr_reg;
    assign inak_flags = inak_reg;
    assign mps_bytes  = mps_reg;
    assign dflt_mode  = dflt_reg;
    assign id_vendor  = VENDOR_ID;
    assign id_product = PRODUCT_ID;
    assign id_device  = DEVICE_ID;

    property p_nak_empty;
        @(posedge core_clk) disable iff (!rst_n)
        tok_valid && tok_in && !tok_setup && tok_ep == 4'h1 &&
        !full_reg[3] && st_reg == UBM_IDLE
        |=> ack_valid && ack_nak && inak_reg[1] ##[0:2] irq_req;
    endproperty
    a_nak_empty: assert property (p_nak_empty)
        else $error("empty IN buffer not NAKed with in-NAK set");

    property p_setup_ack;
        @(posedge core_clk) disable iff (!rst_n)
        tok_valid && tok_setup && !tok_ep[3] && st_reg == UBM_IDLE
        |=> ack_valid && !ack_nak && st_reg == UBM_XFER;
    endproperty
    a_setup_ack: assert property (p_setup_ack)
        else $error("setup token was refused");

    property p_pair_odd;
        @(posedge core_clk) disable iff (!rst_n)
        tok_valid && !tok_setup && tok_in && tok_ep == 4'h2 && pair_en[0]
        && pin_reg[0] && st_reg == UBM_IDLE |=> cur_reg == 4'h7;
    endproperty
    a_pair_odd: assert property (p_pair_odd)
        else $error("paired IN token did not use odd buffer");

    property p_iso_fit;
        @(posedge core_clk) disable iff (!rst_n)
        iso_cfg_wr && new_total > 11'(ISO_UNITS)
        |=> iso_cfg_err &&
            isz_reg[$past(iso_cfg_idx)] == $past(isz_reg[iso_cfg_idx]);
    endproperty
    a_iso_fit: assert property (p_iso_fit)
        else $error("iso allocation overflow accepted");

    property p_auto_inc;
        @(posedge core_clk) disable iff (!rst_n)
        cpu_auto && (cpu_rd || cpu_wr) && !cpu_ptr_load
        |=> aptr_reg == 6'($past(aptr_reg) + 6'h01);
    endproperty
    a_auto_inc: assert property (p_auto_inc)
        else $error("auto pointer did not advance");

    property p_alt0_zero;
        @(posedge core_clk) disable iff (!rst_n)
        dflt_reg && alt_set == 2'h0 && mps_ep != 4'h0 ##1 dflt_reg
        |-> mps_bytes == MPS_0;
    endproperty
    a_alt0_zero: assert property (p_alt0_zero)
        else $error("setting 0 granted packet space");

    property p_ep8_alt2;
        @(posedge core_clk) disable iff (!rst_n)
        dflt_reg && alt_set == 2'h2 && mps_ep == 4'h8 ##1 dflt_reg
        |-> mps_bytes == MPS_256;
    endproperty
    a_ep8_alt2: assert property (p_ep8_alt2)
        else $error("EP8 setting 2 not 256 bytes");

    property p_ep0_64;
        @(posedge core_clk) disable iff (!rst_n)
        dflt_reg && mps_ep == 4'h0 ##1 dflt_reg |-> mps_bytes == MPS_64;
    endproperty
    a_ep0_64: assert property (p_ep0_64)
        else $error("endpoint zero not 64 bytes");

    c_nak:   cover property (@(posedge core_clk) ack_valid && ack_nak);
    c_setup: cover property (@(posedge core_clk) ev[VEC_SETUP]);
    c_pair:  cover property (@(posedge core_clk) $rose(pin_reg[0]));
    c_isoerr: cover property (@(posedge core_clk) $rose(iso_cfg_err));
endmodule // ubm_top

// ===== hdl/ubm_pkg.sv
// Purpose: Constants and lookups for the endpoint buffer manager.
// Assumes: One 125 MHz clock; the serial engine and CPU are synchronous.
// Notes: Buffer index is {endpoint[2:0], is_in}.
package ubm_pkg;
    localparam int BUF_BYTES  = 64;
    localparam int NUM_BUFS   = 16;
    localparam int MEM_WORDS  = BUF_BYTES * NUM_BUFS;
    localparam int SETUP_LEN  = 8;
    localparam int ISO_HALF   = 1024;
    localparam int ISO_STEP   = 16;
    localparam int ISO_UNITS  = ISO_HALF / ISO_STEP;
    localparam int NUM_ISO    = 16;
    localparam int VEC_SETUP  = 16;
    localparam int VEC_INAK   = 17;
    localparam int VEC_ISO    = 18;
    localparam int NUM_VEC    = 19;
    localparam logic [8:0] MPS_0   = 9'h000;
    localparam logic [8:0] MPS_16  = 9'h010;
    localparam logic [8:0] MPS_64  = 9'h040;
    localparam logic [8:0] MPS_256 = 9'h100;

    typedef enum logic [1:0] {
        UBM_IDLE = 2'b01,
        UBM_XFER = 2'b10
    } ubm_state_t;

    // Packet sizes of the built-in personality; alternate setting 3 is
    // not offered, so it reports zero everywhere except endpoint zero.
    function automatic logic [8:0] ubm_dflt_mps(input logic [3:0] ep,
                                                input logic       in,
                                                input logic [1:0] alt);
        logic [8:0] m;
        m = MPS_0;
        if (ep == 4'h0) begin
            m = MPS_64;
        end else if (alt == 2'h1 || alt == 2'h2) begin
            case (ep)
                4'h1:    m = in ? ((alt == 2'h1) ? MPS_16 : MPS_64) : MPS_0;
                4'h2,
                4'h4,
                4'h6:    m = MPS_64;
                4'h8:    m = (alt == 2'h1) ? MPS_16 : MPS_256;
                4'h9,
                4'hA:    m = MPS_16;
                default: m = MPS_0;
            endcase
        end
        return m;
    endfunction
endpackage

// ===== hdl/ubm_irq_vec.sv
// Purpose: Sticky endpoint events with one vector per event source.
// Assumes: Ack clears only the vector currently shown.
// Notes: Lowest index has highest priority.
`timescale 1ns/100ps
module ubm_irq_vec
    import ubm_pkg::*;
#(
    parameter int N = NUM_VEC,
    parameter int W = 5
) (
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    input  wire logic [N-1:0] ev_set,
    input  wire logic         ev_ack,
    output logic              irq_req,
    output logic [W-1:0]      irq_vec
);
    logic [N-1:0] pend_reg;
    logic [N-1:0] pend_next;
    logic [W-1:0] vec_reg;
    logic [W-1:0] vec_next;

    always_comb begin
        pend_next = pend_reg;
        if (ev_ack && pend_reg[vec_reg]) begin
            pend_next[vec_reg] = 1'b0;
        end
        // A new event in the ack cycle survives the clear.
        pend_next = pend_next | ev_set;
        vec_next = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (pend_next[i]) begin
                vec_next = W'(i);
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_reg <= '0;
            vec_reg  <= '0;
        end else begin
            pend_reg <= pend_next;
            vec_reg  <= vec_next;
        end
    end

    assign irq_req = |pend_reg;
    assign irq_vec = vec_reg;

    property p_set_wins;
        @(posedge core_clk) disable iff (!rst_n)
        |ev_set |=> irq_req && pend_reg[$past(vec_next)];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("event lost or vector not pending");

    property p_vec_lowest;
        @(posedge core_clk) disable iff (!rst_n)
        irq_req |-> (pend_reg & ((N'(1) << vec_reg) - N'(1))) == '0;
    endproperty
    a_vec_lowest: assert property (p_vec_lowest)
        else $error("vector is not the lowest pending event");
endmodule // ubm_irq_vec

// ===== tb/ubm_host_model.sv
// Purpose: Serial engine side model that issues tokens and packets.
// Assumes: The answer to a token arrives within a few cycles.
// Notes: Released data is inverted so a stale byte never matches.
`timescale 1ns/100ps
module ubm_host_model (
    input  wire logic       core_clk,
    input  wire logic       ack_valid,
    input  wire logic       ack_nak,
    output logic            tok_valid,
    output logic            tok_in,
    output logic            tok_setup,
    output logic [3:0]      tok_ep,
    output logic            sie_wr,
    output logic            sie_rd,
    output logic [7:0]      sie_wdata,
    output logic            sie_done
);
    logic nak;
    initial begin
        {tok_valid, tok_in, tok_setup, tok_ep} = '0;
        {sie_wr, sie_rd, sie_wdata, sie_done} = '0;
    end
    task automatic token(input logic [3:0] ep, input logic in,
                         input logic setup);
        int n;
        @(posedge core_clk);
        #1 tok_valid = 1'h1;
        tok_ep = ep;
        tok_in = in;
        tok_setup = setup;
        @(posedge core_clk);
        #1 tok_valid = 1'h0;
        tok_setup = 1'h0;
        n = 0;
        while (ack_valid !== 1'h1 && n < 4) begin
            @(posedge core_clk);
            #1 n++;
        end
        nak = (n < 4) ? ack_nak : 1'bx;
    endtask
    task automatic packet(input int len, input logic [7:0] base,
                          input logic rd);
        for (int i = 0; i < len; i++) begin
            @(posedge core_clk);
            #1 sie_wr = !rd;
            sie_rd = rd;
            sie_wdata = base + 8'(i);
        end
        @(posedge core_clk);
        #1 sie_wr = 1'h0;
        sie_rd = 1'h0;
        sie_wdata = ~sie_wdata;
        sie_done = 1'h1;
        @(posedge core_clk);
        #1 sie_done = 1'h0;
    endtask
endmodule // ubm_host_model

// ===== tb/usb_endpoint_buffer_manager_bench.sv
// Purpose: Self-checking bench for the endpoint buffer manager.
// Assumes: Design defaults for the identity parameters.
// Notes: The iso engine port never writes; frame start is pulsed only in t_iso.
`timescale 1ns/100ps
module usb_endpoint_buffer_manager_bench;
    import ubm_pkg::*;
    logic core_clk = 1'h0;
    logic rst_n = 1'h0;
    logic tok_valid, tok_in, tok_setup, sie_wr, sie_rd, sie_done, sof;
    logic sie_iso_wr, sie_iso_rd, cpu_wr, cpu_rd, cpu_auto, cpu_ptr_load;
    logic cpu_hand, iso_cfg_wr, cpu_iso_wr, cpu_iso_rd, irq_ack, mps_in;
    logic eeprom_present, i2c_pulled_up, ack_valid, ack_nak, iso_cfg_err;
    logic irq_req, dflt_mode;
    logic [1:0]  alt_set;
    logic [2:0]  setup_addr, pair_en;
    logic [3:0]  tok_ep, sie_iso_idx, cpu_buf, iso_cfg_idx, cpu_iso_idx;
    logic [3:0]  mps_ep;
    logic [4:0]  irq_vec;
    logic [5:0]  cpu_addr, iso_cfg_units;
    logic [6:0]  ack_len, cpu_len, buf_len;
    logic [7:1]  inak_clr, inak_flags;
    logic [7:0]  sie_wdata, sie_rdata, sie_iso_rdata, cpu_wdata, cpu_rdata;
    logic [7:0]  setup_rdata, cpu_iso_rdata;
    logic [8:0]  mps_bytes;
    logic [9:0]  sie_iso_ofs;
    logic [15:0] buf_full, id_vendor, id_product, id_device;
    int err_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [3:0] eps [6] = '{4'h0, 4'h1, 4'h2, 4'h8, 4'h9, 4'h3};
    logic [8:0] mps_tab [18] = '{9'h040, 9'h000, 9'h000, 9'h000, 9'h000,
        9'h000, 9'h040, 9'h010, 9'h040, 9'h010, 9'h010, 9'h000, 9'h040,
        9'h040, 9'h040, 9'h100, 9'h010, 9'h000};

    ubm_top dut (.*);
    ubm_host_model host (.*);

    always #4 core_clk = ~core_clk;

    task automatic summarize();
        if (err_count == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            summarize();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic t_default();
        step(2);
        chk(dflt_mode, 1'h1);
        chk(id_vendor, 16'hA5A5);
        for (int a = 0; a < 3; a++) begin
            for (int i = 0; i < 6; i++) begin
                alt_set = 2'(a);
                mps_ep = eps[i];
                step(1);
                chk(mps_bytes, mps_tab[a * 6 + i]);
            end
        end
        mps_in = 1'h0;
        mps_ep = 4'h1;
        step(1);
        chk(mps_bytes, 9'h000);
        eeprom_present = 1'h1;
        step(2);
        chk(dflt_mode, 1'h0);
        chk(mps_bytes, 9'h000);
    endtask

    task automatic t_in_nak();
        host.token(4'h1, 1'h1, 1'h0);
        chk(host.nak, 1'h1);
        step(2);
        chk(inak_flags, 7'h01);
        chk(irq_vec, 5'h11);
        irq_ack = 1'h1;
        inak_clr = 7'h01;
        step(1);
        irq_ack = 1'h0;
        inak_clr = 7'h00;
        step(2);
        chk({irq_req, inak_flags}, 8'h00);
    endtask

    task automatic t_out();
        host.token(4'h1, 1'h0, 1'h0);
        chk(host.nak, 1'h0);
        host.packet(2, 8'h3C, 1'h0);
        cpu_buf = 4'h2;
        cpu_addr = 6'h01;
        step(2);
        chk({buf_full[2], buf_len}, 8'h82);
        chk(irq_vec, 5'h02);
        chk(cpu_rdata, 8'h3D);
        host.token(4'h1, 1'h0, 1'h0);
        chk(host.nak, 1'h1);
    endtask

    task automatic t_in();
        cpu_buf = 4'h3;
        cpu_addr = 6'h00;
        cpu_ptr_load = 1'h1;
        step(1);
        cpu_ptr_load = 1'h0;
        cpu_auto = 1'h1;
        cpu_wr = 1'h1;
        cpu_wdata = 8'hC3;
        step(1);
        cpu_wdata = 8'hC4;
        step(1);
        {cpu_wr, cpu_auto} = '0;
        cpu_hand = 1'h1;
        cpu_len = 7'h02;
        cpu_addr = 6'h01;
        step(1);
        cpu_hand = 1'h0;
        host.token(4'h1, 1'h1, 1'h0);
        chk({host.nak, ack_len}, 8'h02);
        chk(cpu_rdata, 8'hC4);
        step(1);
        chk(sie_rdata, 8'hC3);
        host.packet(1, 8'h00, 1'h1);
        chk(buf_full[3], 1'h0);
    endtask

    task automatic t_setup();
        host.token(4'h0, 1'h0, 1'h1);
        chk(host.nak, 1'h0);
        host.packet(8, 8'h80, 1'h0);
        setup_addr = 3'h7;
        step(1);
        chk(setup_rdata, 8'h87);
        chk(buf_full[0], 1'h0);
    endtask

    task automatic t_pair();
        pair_en = 3'h1;
        for (int k = 0; k < 2; k++) begin
            host.token(4'h2, 1'h0, 1'h0);
            chk(host.nak, 1'h0);
            host.packet(1, 8'h11, 1'h0);
        end
        chk(buf_full[7:4], 4'h5);
        host.token(4'h3, 1'h0, 1'h0);
        chk(host.nak, 1'h1);
        pair_en = 3'h0;
    endtask

    task automatic t_iso();
        cpu_iso_idx = 4'h1;
        cpu_iso_wr = 1'h1;
        cpu_wdata = 8'h5A;
        step(1);
        cpu_wdata = 8'hA5;
        step(1);
        cpu_iso_wr = 1'h0;
        sie_iso_idx = 4'h1;
        sie_iso_ofs = 10'h001;
        sof = 1'h1;
        step(1);
        sof = 1'h0;
        step(1);
        chk(sie_iso_rdata, 8'hA5);
        sof = 1'h1;
        step(1);
        sof = 1'h0;
        step(1);
        chk(cpu_iso_rdata, 8'h5A);
        cpu_iso_rd = 1'h1;
        step(1);
        cpu_iso_rd = 1'h0;
        step(1);
        chk(cpu_iso_rdata, 8'hA5);
    endtask

    task automatic cfg(input logic [3:0] i, input logic [5:0] u,
                       input logic e);
        iso_cfg_idx = i;
        iso_cfg_units = u;
        iso_cfg_wr = 1'h1;
        step(1);
        iso_cfg_wr = 1'h0;
        step(1);
        chk(iso_cfg_err, e);
    endtask

    initial begin
        {sof, sie_iso_wr, sie_iso_rd, cpu_wr, cpu_rd} = '0;
        {cpu_auto, cpu_ptr_load, cpu_hand, iso_cfg_wr, cpu_iso_wr} = '0;
        {cpu_iso_rd, irq_ack, eeprom_present, alt_set, setup_addr} = '0;
        {pair_en, sie_iso_idx, cpu_buf, iso_cfg_idx, cpu_iso_idx} = '0;
        {mps_ep, cpu_addr, iso_cfg_units, cpu_len, inak_clr} = '0;
        {cpu_wdata, sie_iso_ofs} = '0;
        i2c_pulled_up = 1'h1;
        mps_in = 1'h1;
        step(10);
        rst_n = 1'h1;
        t_default();
        t_in_nak();
        t_out();
        t_in();
        t_setup();
        t_pair();
        cfg(4'h0, 6'h28, 1'h0);
        cfg(4'h1, 6'h1E, 1'h1);
        cfg(4'h1, 6'h18, 1'h0);
        t_iso();
        summarize();
    end
endmodule // usb_endpoint_buffer_manager_bench
